//--- inc/fdo_pkg.sv
// Shared constants and types of the divider and output stage block
package fdo_pkg;
	// ****************************************
	// Sizes
	// ****************************************
	localparam int NDIV   = 8;
	localparam int NPATH  = 12;
	localparam int INT_W  = 8;
	localparam int FRAC_W = 43;
	localparam int RAT_W  = 51;
	// ****************************************
	// Address map (byte addresses, word index in offsets)
	// ****************************************
	localparam logic [3:0]  DIV_REGION  = 4'h0;
	localparam logic [2:0]  PATH_REGION = 3'h1;
	localparam logic [11:0] MUX_ADDR    = 12'h400;
	localparam logic [2:0]  OFS_INT     = 3'h0;
	localparam logic [2:0]  OFS_FLO     = 3'h1;
	localparam logic [2:0]  OFS_FHI     = 3'h2;
	localparam logic [2:0]  OFS_FINE    = 3'h3;
	localparam logic [2:0]  OFS_RATE    = 3'h4;
	localparam logic [2:0]  OFS_DIV     = 3'h0;
	localparam logic [2:0]  OFS_HIGH    = 3'h1;
	localparam logic [2:0]  OFS_STEP    = 3'h2;
	localparam logic [2:0]  OFS_CTRL    = 3'h3;
	// ****************************************
	// Reset values and arithmetic constants
	// ****************************************
	localparam logic [7:0]  INT_RST   = 8'h0E;
	localparam logic [31:0] DIVO_RST  = 32'h00000002;
	localparam logic [31:0] DIVO_MIN  = 32'h00000002;
	localparam logic [31:0] COARSE_MIN_DIV = 32'h00000005;
	localparam logic signed [34:0] MIN_PORTION = 35'sh000000002;
	localparam logic [RAT_W-1:0] RATIO_ONE  = 51'h80000000000;
	localparam logic [RAT_W-1:0] DELTA_FAST = 51'h1000000000;
	localparam logic [RAT_W-1:0] DELTA_MED  = 51'h200000000;
	localparam logic [RAT_W-1:0] DELTA_SLOW = 51'h40000000;
	localparam int PS_SHIFT = 16;
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		RATE_FAST = 2'b00,
		RATE_MED  = 2'b01,
		RATE_SLOW = 2'b10
	} fdo_rate_type;
	typedef enum logic {
		PH_LOW  = 1'b0,
		PH_HIGH = 1'b1
	} fdo_phase_type;
	typedef struct packed {
		logic [31:0] div;
		logic [31:0] high;
	} fdo_path_cfg_type;
endpackage

//--- rtl/fdo_out_path.sv
// One output path: integer divider, pulse width and coarse phase step
`timescale 1ns/1ps
module fdo_out_path (
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	input  wire logic                      tick,
	input  wire fdo_pkg::fdo_path_cfg_type cfg,
	input  wire logic                      step_wr,
	input  wire logic signed [31:0]        step_val,
	output logic                           q,
	output logic                           step_pend
);
	import fdo_pkg::*;

	fdo_phase_type      ph_r;
	logic [34:0]        cnt_r;
	logic [34:0]        hi_len_r;
	logic [34:0]        lo_len_r;
	logic               q_r;
	logic               req_r;
	logic signed [31:0] step_r;
	logic [31:0]        div_eff;
	logic signed [34:0] step_x;
	logic signed [34:0] base_hi;
	logic signed [34:0] base_lo;
	logic signed [34:0] adj_hi;
	logic signed [34:0] adj_lo;
	logic signed [34:0] hi_n;
	logic signed [34:0] lo_n;
	logic [34:0]        cnt_inc;
	logic               last;
	logic               boundary;

	// ****************************************
	// Lengths of the next period
	// ****************************************
	always_comb begin
		div_eff = (cfg.div < DIVO_MIN) ? DIVO_MIN : cfg.div;
		step_x = '0;
		if (req_r && div_eff >= COARSE_MIN_DIV) begin
			step_x = 35'(step_r);
		end
		if (cfg.high == 32'h00000000) begin
			base_hi = $signed({3'h0, div_eff - (div_eff >> 1)});
			base_lo = $signed({3'h0, div_eff >> 1});
			adj_hi  = step_x >>> 1;
			adj_lo  = step_x - adj_hi;
		end else begin
			base_hi = $signed({3'h0, cfg.high});
			base_lo = $signed({3'h0, div_eff}) - $signed({3'h0, cfg.high});
			adj_hi  = '0;
			adj_lo  = step_x;
		end
		hi_n = base_hi + adj_hi;
		lo_n = base_lo + adj_lo;
		if (step_x != '0 && hi_n < MIN_PORTION) begin
			hi_n = MIN_PORTION;
		end
		if (step_x != '0 && lo_n < MIN_PORTION) begin
			lo_n = MIN_PORTION;
		end
		// High count not below divide value would leave no low time
		if (lo_n < 35'sh000000001) begin
			lo_n = 35'sh000000001;
		end
	end

	assign cnt_inc  = 35'(cnt_r + 35'h000000001);
	assign last     = cnt_inc >= ((ph_r == PH_HIGH) ? hi_len_r : lo_len_r);
	assign boundary = tick && last && ph_r == PH_LOW;

	// ****************************************
	// Period counter, output is always high-going
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph_r     <= PH_LOW;
			cnt_r    <= '0;
			q_r      <= 1'b0;
			hi_len_r <= 35'h000000001;
			lo_len_r <= 35'h000000001;
		end else if (tick) begin
			if (last) begin
				cnt_r <= '0;
				unique case (ph_r)
					PH_LOW: begin
						ph_r     <= PH_HIGH;
						q_r      <= 1'b1;
						hi_len_r <= 35'(hi_n);
						lo_len_r <= 35'(lo_n);
					end
					PH_HIGH: begin
						ph_r <= PH_LOW;
						q_r  <= 1'b0;
					end
				endcase
			end else begin
				cnt_r <= cnt_inc;
			end
		end
	end

	// ****************************************
	// Coarse step request, a new write wins over consumption
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_r  <= 1'b0;
			step_r <= '0;
		end else if (step_wr) begin
			req_r  <= 1'b1;
			step_r <= step_val;
		end else if (boundary) begin
			req_r <= 1'b0;
		end
	end

	assign q         = q_r;
	assign step_pend = req_r;
endmodule // fdo_out_path

//--- rtl/fdo_top.sv
// Fractional dividers, source muxes and output stages with APB registers
`timescale 1ns/1ps
module fdo_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output logic [11:0]      true_output_pin,
	output logic [11:0]      complement_output_pin
);
	import fdo_pkg::*;

	// ****************************************
	// Register state
	// ****************************************
	logic [INT_W-1:0]   int_r [NDIV];
	logic [FRAC_W-1:0]  frac_r [NDIV];
	fdo_rate_type       rate_r [NDIV];
	logic signed [55:0] pend_r [NDIV];
	logic [RAT_W-1:0]   acc_r [NDIV];
	logic [NDIV-1:0]    tick_r;
	fdo_path_cfg_type   cfg_r [NPATH];
	logic signed [31:0] stepv_r [NPATH];
	logic [NPATH-1:0]   single_r;
	logic [NPATH-1:0]   inv_r;
	logic               stage4_source_select_r;
	logic               stage7_source_select_r;
	logic [31:0]        prdata_r;
	logic               pready_r;
	logic               pslverr_r;
	logic [11:0]        true_r;
	logic [11:0]        comp_r;

	logic [NPATH-1:0]   path_q;
	logic [NPATH-1:0]   path_pend;
	logic [NPATH-1:0]   path_tick;
	logic [NPATH-1:0]   step_wr;
	logic [NDIV-1:0]    fine_wr;
	logic [NDIV-1:0]    fine_busy;

	// ****************************************
	// Address decode
	// ****************************************
	logic       acc_wr;
	logic       setup;
	logic       div_hit;
	logic       path_hit;
	logic       mux_hit;
	logic       legal;
	logic [2:0] dn;
	logic [3:0] pn;
	logic [2:0] wo;
	logic [31:0] rd;

	assign setup    = psel && !penable;
	assign acc_wr   = psel && penable && pready_r && pwrite;
	assign dn       = paddr[7:5];
	assign pn       = paddr[8:5];
	assign wo       = paddr[4:2];
	assign div_hit  = paddr[11:8] == DIV_REGION && wo <= OFS_RATE;
	assign path_hit = paddr[11:9] == PATH_REGION && pn < 4'(NPATH) &&
		wo <= OFS_CTRL;
	assign mux_hit  = paddr[11:2] == MUX_ADDR[11:2];
	assign legal    = div_hit || path_hit || mux_hit;

	// ****************************************
	// Fractional dividers
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < NDIV; gi++) begin : g_div
			logic [55:0]        mag;
			logic [55:0]        delta;
			logic [55:0]        app;
			logic signed [55:0] offs;
			logic signed [55:0] ratio;
			logic [RAT_W-1:0]   sum;
			logic               hit;
			logic signed [55:0] add;

			assign fine_wr[gi] = acc_wr && div_hit && dn == 3'(gi) &&
				wo == OFS_FINE;
			assign fine_busy[gi] = pend_r[gi] != '0;

			always_comb begin
				mag = pend_r[gi] < 0 ? 56'(-pend_r[gi]) : 56'(pend_r[gi]);
				unique case (rate_r[gi])
					RATE_FAST: delta = 56'(DELTA_FAST);
					RATE_MED:  delta = 56'(DELTA_MED);
					default:   delta = 56'(DELTA_SLOW);
				endcase
				app  = (mag < delta) ? mag : delta;
				// Negative pending shrinks ratio, so edges come early
				offs = pend_r[gi] < 0 ? -$signed(app) : $signed(app);
				ratio = $signed({5'h00, int_r[gi], frac_r[gi]}) + offs;
				sum = RAT_W'(acc_r[gi] + RATIO_ONE);
				hit = $signed({5'h00, sum}) >= ratio;
				add = fine_wr[gi] ? (56'(signed'(pwdata)) <<< PS_SHIFT) : '0;
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					acc_r[gi]  <= '0;
					tick_r[gi] <= 1'b0;
				end else begin
					tick_r[gi] <= hit;
					acc_r[gi]  <= hit ? RAT_W'(sum - RAT_W'(ratio)) : sum;
				end
			end

			// Writes add to what is still pending, nothing is dropped
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pend_r[gi] <= '0;
				end else begin
					pend_r[gi] <= pend_r[gi] - offs + add;
				end
			end

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					int_r[gi]  <= INT_RST;
					frac_r[gi] <= '0;
					rate_r[gi] <= RATE_SLOW;
				end else if (acc_wr && div_hit && dn == 3'(gi)) begin
					if (wo == OFS_INT) begin
						int_r[gi] <= pwdata[INT_W-1:0];
					end
					if (wo == OFS_FLO) begin
						frac_r[gi][31:0] <= pwdata;
					end
					if (wo == OFS_FHI) begin
						frac_r[gi][FRAC_W-1:32] <= pwdata[FRAC_W-33:0];
					end
					if (wo == OFS_RATE) begin
						rate_r[gi] <= fdo_rate_type'(pwdata[1:0]);
					end
				end
			end
		end
	endgenerate

	// ****************************************
	// Source selection for the output paths
	// ****************************************
	always_comb begin
		for (int p = 0; p < 8; p++) begin
			path_tick[p] = tick_r[p / 2];
		end
		path_tick[8]  = stage4_source_select_r ? tick_r[5] : tick_r[4];
		path_tick[9]  = tick_r[5];
		path_tick[10] = tick_r[6];
		path_tick[11] = stage7_source_select_r ? tick_r[7] : tick_r[6];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage4_source_select_r <= 1'b0;
			stage7_source_select_r <= 1'b0;
		end else if (acc_wr && mux_hit) begin
			stage4_source_select_r <= pwdata[0];
			stage7_source_select_r <= pwdata[1];
		end
	end

	// ****************************************
	// Output paths
	// ****************************************
	genvar gp;
	generate
		for (gp = 0; gp < NPATH; gp++) begin : g_path
			logic hit;

			assign hit = acc_wr && path_hit && pn == 4'(gp);
			assign step_wr[gp] = hit && wo == OFS_STEP;

			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					cfg_r[gp].div  <= DIVO_RST;
					cfg_r[gp].high <= '0;
					stepv_r[gp]    <= '0;
					single_r[gp]   <= 1'b0;
					inv_r[gp]      <= 1'b0;
				end else if (hit) begin
					if (wo == OFS_DIV) begin
						cfg_r[gp].div <= pwdata;
					end
					if (wo == OFS_HIGH) begin
						cfg_r[gp].high <= pwdata;
					end
					if (wo == OFS_STEP) begin
						stepv_r[gp] <= pwdata;
					end
					if (wo == OFS_CTRL) begin
						single_r[gp] <= pwdata[0];
						inv_r[gp]    <= pwdata[1];
					end
				end
			end

			fdo_out_path i_fdo_out_path (
				.pclk      (pclk),
				.presetn   (presetn),
				.tick      (path_tick[gp]),
				.cfg       (cfg_r[gp]),
				.step_wr   (step_wr[gp]),
				.step_val  (signed'(pwdata)),
				.q         (path_q[gp]),
				.step_pend (path_pend[gp])
			);
		end
	endgenerate

	// ****************************************
	// Pin drivers
	// ****************************************
	// Differential always drives the complement inverted
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			true_r <= '0;
			comp_r <= '0;
		end else begin
			true_r <= path_q;
			comp_r <= path_q ^ (~single_r | inv_r);
		end
	end

	// ****************************************
	// Read data
	// ****************************************
	always_comb begin
		rd = '0;
		if (div_hit) begin
			unique case (wo)
				OFS_INT:  rd = 32'(int_r[dn]);
				OFS_FLO:  rd = frac_r[dn][31:0];
				OFS_FHI:  rd = 32'(frac_r[dn][FRAC_W-1:32]);
				OFS_FINE: rd = 32'(fine_busy[dn]);
				default:  rd = 32'(rate_r[dn]);
			endcase
		end else if (path_hit) begin
			unique case (wo)
				OFS_DIV:  rd = cfg_r[pn].div;
				OFS_HIGH: rd = cfg_r[pn].high;
				OFS_STEP: rd = stepv_r[pn];
				default:  rd = {28'h0000000, path_pend[pn], path_q[pn],
					inv_r[pn], single_r[pn]};
			endcase
		end else if (mux_hit) begin
			rd = {30'h00000000, stage7_source_select_r,
				stage4_source_select_r};
		end
	end

	// ****************************************
	// APB answer: one access cycle, data caught at setup
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r  <= '0;
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup && !legal;
			if (setup) begin
				prdata_r <= pwrite ? 32'h00000000 : rd;
			end
		end
	end

	assign prdata                = prdata_r;
	assign pready                = pready_r;
	assign pslverr               = pslverr_r;
	assign true_output_pin       = true_r;
	assign complement_output_pin = comp_r;
endmodule // fdo_top

//--- bench/fdo_top_chk.sv
// Checker of the bus handshake and of the output pin relations
`timescale 1ns/1ps
module fdo_top_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [11:0] true_output_pin,
	input wire logic [11:0] complement_output_pin
);
	import fdo_pkg::*;
	logic       wr_acc;
	logic [1:0] ctrl0_r;
	logic [1:0] quiet_r;
	logic       same_r;
	assign wr_acc = psel && penable && pready && pwrite;
	// Pins lag a control write by two edges, so wait until quiet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl0_r <= 2'h0;
			quiet_r <= 2'h0;
		end else if (wr_acc && paddr[11:2] == 10'h083) begin
			ctrl0_r <= pwdata[1:0];
			quiet_r <= 2'h0;
		end else if (quiet_r != 2'h3) begin
			quiet_r <= quiet_r + 2'h1;
		end
	end
	// Paths 0 and 1 agree until either one is reprogrammed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			same_r <= 1'b1;
		else if (wr_acc && paddr[11:6] == 6'h08 && paddr[3:2] != 2'h3)
			same_r <= 1'b0;
	end
	// ****
	// Properties
	// ****
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable && pready;
	endsequence
	a_ready_follows: assert property (s_setup |=> s_access)
		else $error("no ready in the cycle after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_ready_cause: assert property ($rose(pready) |-> $past(psel && !penable))
		else $error("ready without a setup cycle");
	a_err_data_zero: assert property (pslverr && !pwrite |-> pready && prdata == 32'h0)
		else $error("refused read with data or without ready");
	a_diff_inverse: assert property (
		quiet_r[1] && !ctrl0_r[0] |-> complement_output_pin[0] == !true_output_pin[0])
		else $error("differential pair not complementary");
	a_single_copy: assert property (
		quiet_r[1] && ctrl0_r[0]
		|-> complement_output_pin[0] == (true_output_pin[0] ^ ctrl0_r[1]))
		else $error("single ended copy wrong polarity");
	a_dual_match: assert property (
		same_r |-> true_output_pin[1] == true_output_pin[0])
		else $error("dual stage paths differ");
	a_dual_rest: assert property (
		true_output_pin[5] == true_output_pin[4] &&
		true_output_pin[7] == true_output_pin[6])
		else $error("untouched dual stage paths differ");
	a_high_min: assert property (
		$rose(true_output_pin[0]) |-> true_output_pin[0] [*8])
		else $error("high portion shorter than one divider cycle");
	a_low_min: assert property (
		$fell(true_output_pin[0]) |-> !true_output_pin[0] [*8])
		else $error("low portion shorter than one divider cycle");
endmodule // fdo_top_chk

bind fdo_top fdo_top_chk i_fdo_top_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.true_output_pin(true_output_pin),
	.complement_output_pin(complement_output_pin));

//--- bench/test_fractional_divider_output_stage.sv
// Self-checking bench of the divider and output stage block
`timescale 1ns/1ps
module test_fractional_divider_output_stage;
	import fdo_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [11:0] true_output_pin;
	logic [11:0] complement_output_pin;
	int          fails;
	int          comparisons;
	int          cycles;
	int          seed;
	int          mon_sel;
	int          cnt;
	logic        last;
	logic [31:0] v;
	int          el;
	time         t0;
	logic [32:0] rd_q[$];
	logic [31:0] w_q[$];

	fdo_top i_fdo_top (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.true_output_pin(true_output_pin),
		.complement_output_pin(complement_output_pin));

	initial begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	// ****
	// Bus and checking tasks
	// ****
	task automatic end_of_test;
		if (fails == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic cmp_word(input logic [32:0] e, input logic [32:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("unexpected read at %0t: want %h got %h", $time, e, g);
		end
	endtask
	task automatic cmp_width(input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("unexpected width at %0t: want %h got %h", $time, e, g);
		end
	endtask
	// No wait count is assumed: only the cycle ceiling ends a hang
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
		rd_q.push_back({err, e});
		xfer(1'b0, a, 32'h0);
	endtask
	task automatic wait_lvl(input logic b);
		do
			@(posedge pclk);
		while (true_output_pin[mon_sel] !== b);
	endtask
	// Widths in divider cycles of the stepped period and the one after
	task automatic run_case(input int p, input logic [31:0] dv,
		input logic [31:0] hi, input logic [31:0] st, input int t,
		input int e0, input int e1, input int e2, input int e3);
		logic [11:0] b;
		b = 12'h200 + 12'(p * 32);
		mon_sel = p;
		wr(b, dv);
		wr(b + 12'h4, hi);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		wr(b + 12'h8, st);
		wait_lvl(1'b1);
		@(posedge pclk);
		w_q.push_back(32'(e0 * t));
		w_q.push_back(32'(e1 * t));
		w_q.push_back(32'(e2 * t));
		w_q.push_back(32'(e3 * t));
		while (w_q.size() != 0)
			@(posedge pclk);
	endtask
	// ****
	// Result watcher and cycle ceiling
	// ****
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && rd_q.size() > 0)
			cmp_word(rd_q.pop_front(), {pslverr, prdata});
		if (true_output_pin[mon_sel] !== last) begin
			if (w_q.size() > 0)
				cmp_width(w_q.pop_front(), cnt);
			cnt = 1;
			last = true_output_pin[mon_sel];
		end else
			cnt++;
		cycles++;
		if (cycles == 30000) begin
			fails++;
			end_of_test();
		end
	end

	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		presetn = 1'b0;
		fails = 0;
		comparisons = 0;
		cycles = 0;
		seed = 18239;
		mon_sel = 0;
		cnt = 0;
		last = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h000, 32'h0000000E, 1'b0);
		rd(12'h010, 32'h00000002, 1'b0);
		rd(12'h200, 32'h00000002, 1'b0);
		rd(12'h204, 32'h00000000, 1'b0);
		rd(12'h400, 32'h00000000, 1'b0);
		wr(12'hFFC, 32'h0000FFFF);
		rd(12'hFFC, 32'h00000000, 1'b1);
		v = $random(seed);
		wr(12'h264, v >> 1);
		rd(12'h264, v >> 1, 1'b0);
		wr(12'h260, v | 32'h80000000);
		rd(12'h260, v | 32'h80000000, 1'b0);
		wr(12'h024, v);
		rd(12'h024, v, 1'b0);
		// Fraction kept in 1/8 to 1/4, away from the spur points
		wr(12'h028, (~v & 32'hFFFFF8FF) | 32'h00000100);
		rd(12'h028, (~v & 32'h000000FF) | 32'h00000100, 1'b0);
		for (int c = 1; c < 5; c++) begin
			wr(12'h20C, 32'(c % 4));
			repeat (60) @(posedge pclk);
		end
		run_case(0, 32'h5, 32'h0, 32'h0, 14, 3, 2, 3, 2);
		run_case(0, 32'h5, 32'h1, 32'h0, 14, 1, 4, 1, 4);
		run_case(0, 32'h6, 32'h0, 32'h4, 14, 5, 5, 3, 3);
		run_case(0, 32'h6, 32'h0, 32'h4, 14, 5, 5, 3, 3);
		run_case(0, 32'h6, 32'h0, 32'hFFFFFFFE, 14, 2, 2, 3, 3);
		run_case(0, 32'h6, 32'h0, 32'hFFFFFFF6, 14, 2, 2, 3, 3);
		run_case(0, 32'h6, 32'h2, 32'h3, 14, 2, 7, 2, 4);
		run_case(0, 32'h4, 32'h0, 32'hFFFFFFFE, 14, 2, 2, 2, 2);
		run_case(0, 32'h7, 32'h0, 32'h1, 14, 4, 4, 4, 3);
		run_case(8, 32'h2, 32'h0, 32'h0, 14, 1, 1, 1, 1);
		wr(12'h0A0, 32'h00000014);
		wr(12'h0E0, 32'h00000010);
		wr(12'h400, 32'h00000003);
		run_case(8, 32'h2, 32'h0, 32'h0, 20, 1, 1, 1, 1);
		run_case(11, 32'h2, 32'h0, 32'h0, 16, 1, 1, 1, 1);
		// Two advance steps of 2^20 ps: slow needs 128 cycles to drain
		for (int r = 0; r < 3; r++) begin
			wr(12'h030, 32'(r));
			wr(12'h02C, 32'hFFF00000);
			wr(12'h02C, 32'hFFF00000);
			repeat (20) @(posedge pclk);
			rd(12'h02C, 32'(r == 2), 1'b0);
			repeat (80) @(posedge pclk);
			rd(12'h02C, 32'(r == 2), 1'b0);
			repeat (100) @(posedge pclk);
			rd(12'h02C, 32'h0, 1'b0);
		end
		// Large fine steps on divider 0 shift each divider 0 tick by 1/128 cycle while they drain
		mon_sel = 0;
		wr(12'h010, 32'h0);
		wr(12'h200, 32'h2);
		for (int s = 0; s < 2; s++) begin
			wait_lvl(1'b0);
			wait_lvl(1'b1);
			t0 = $time;
			wr(12'h00C, s ? 32'h80000000 : 32'h7FFFFFFF);
			repeat (90) begin
				wait_lvl(1'b0);
				wait_lvl(1'b1);
			end
			el = int'(($time - t0) / 100);
			cmp_width(32'h1, 32'(s ? el < 2520 : el > 2520));
		end
		end_of_test();
	end
endmodule // test_fractional_divider_output_stage
